/* File: inc/intack_pkg.sv */
// Notes on behaviour
// RULE_01 - A source is eligible only with request flag 1 and mask flag 0.
// RULE_02 - Eligible maskable requests are taken only while the global accept flag is 1.
// RULE_03 - Request to service start takes 7..32 clocks at level 0, 8..33 at level 1.
// RULE_04 - A request just before a divide may wait until the divide finishes.
// RULE_05 - Among simultaneous eligible requests the level-0 ones are taken first.
// RULE_06 - Among equal levels the lowest source index, the default priority, wins.
// RULE_07 - A request not taken stays pending and is taken once conditions hold.
// RULE_08 - Accept pushes status then counter, clears accept flag, copies level to in-service.
// RULE_09 - After saving context the counter is loaded from the source's vector entry.
// RULE_10 - Maskable return restores the saved counter and status word.
// RULE_11 - Software trap pushes status then counter, clears accept flag, vectors via 003EH/003FH.
// RULE_12 - The software trap is taken regardless of accept flag, level or masks.
// RULE_13 - Software leaves a trap routine with trap return, never maskable return.
// RULE_14 - While servicing, equal or higher priority nests; lower priority stays pending.
// RULE_15 - In-service flag 0 means high-priority service; level bit 0 means high priority.
// RULE_16 - After a service ends, one interrupted instruction runs before the next accept.
// RULE_17 - Status, return, on/off instructions or flag register writes defer accept one instruction.
// RULE_18 - The trap itself does not defer, but its cleared accept flag blocks maskables.
// RULE_19 - Setting a request flag does not depend on the source's level bit.
// RULE_20 - Reset sets the status word to 02H: accept flag clear, in-service flag set.
// RULE_21 - Reset sets every level bit to 1, so all sources start low priority.
// RULE_22 - Accepting a maskable request clears that source's request flag.
package intack_pkg;

    // Source count and widths
    localparam int          NSRC         = 16;
    localparam int          IDXW         = 4;
    localparam int          AW           = 8;

    // Register byte addresses
    localparam logic [7:0]  ADDR_REQ     = 8'h00;
    localparam logic [7:0]  ADDR_MASK    = 8'h04;
    localparam logic [7:0]  ADDR_LEVEL   = 8'h08;
    localparam logic [7:0]  ADDR_STATUS  = 8'h0c;
    localparam logic [7:0]  ADDR_ACKINFO = 8'h10;

    // Status word fields
    localparam int          ST_ACCEPT    = 7;
    localparam int          ST_INSERV    = 1;

    // Reset values
    localparam logic [7:0]  STATUS_RST   = 8'h02;
    localparam logic [15:0] LEVEL_RST    = 16'hffff;
    localparam logic [15:0] MASK_RST     = 16'hffff;
    localparam logic [15:0] REQ_RST      = 16'h0000;

    // Vector table locations
    localparam logic [15:0] VEC_BASE     = 16'h0004;
    localparam logic [15:0] TRAP_VECTOR  = 16'h003e;

    // Latency bounds in CPU clocks
    localparam int          LAT_MIN_HIGH = 7;
    localparam int          LAT_MAX_HIGH = 32;
    localparam int          LAT_MIN_LOW  = 8;
    localparam int          LAT_MAX_LOW  = 33;

    // Save sequence steps, counted from the first cycle after acceptance
    localparam logic [2:0]  SEQ_PUSH_ST  = 3'h0;
    localparam logic [2:0]  SEQ_PUSH_PC  = 3'h1;
    localparam logic [2:0]  SEQ_VECTOR   = 3'h2;
    localparam logic [2:0]  SEQ_LAST_HI  = 3'(LAT_MIN_HIGH - 3);
    localparam logic [2:0]  SEQ_LAST_LO  = 3'(LAT_MIN_LOW - 3);

    typedef enum logic {ACK_IDLE, ACK_SAVE} ack_state_t;

endpackage : intack_pkg

/* File: rtl/cpu_interrupt_acknowledge_logic.sv */
`timescale 1ns/10ps
module cpu_interrupt_acknowledge_logic
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_b,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Peripheral sources
    input  wire logic [15:0] sourceEvent,
    // Instruction sequencer
    input  wire logic        instrDone,
    input  wire logic        instrHold,
    input  wire logic        instrTrap,
    input  wire logic        instrRetMaskable,
    input  wire logic        instrRetTrap,
    input  wire logic        instrAcceptOn,
    input  wire logic        instrAcceptOff,
    input  wire logic [7:0]  restoredStatus,
    input  wire logic [15:0] currentPc,
    // Context save and vectoring
    output logic             ackBusy,
    output logic             stackPush,
    output logic [15:0]      stackData,
    output logic             vectorLoad,
    output logic [15:0]      vectorLocation,
    output logic             serviceStart,
    output logic [7:0]       statusWord
);

    intack_pkg::ack_state_t  state_q;
    logic [2:0]              seqCnt_q;
    logic [2:0]              seqLast_q;
    logic [15:0]             reqQ;
    logic [15:0]             maskQ;
    logic [15:0]             levelQ;
    logic [7:0]              statusQ;
    logic [7:0]              savedStatus_q;
    logic [15:0]             savedPc_q;
    logic                    regTouch_q;
    logic                    lastTrap_q;
    logic [3:0]              lastSrc_q;
    logic                    pready_q;
    logic [31:0]             prdata_q;
    logic                    pslverr_q;
    logic                    stackPush_q;
    logic [15:0]             stackData_q;
    logic                    vectorLoad_q;
    logic                    serviceStart_q;
    logic [15:0]             eligible;
    logic                    anyValid;
    logic [3:0]              winIdx;
    logic                    winLevel;
    logic                    apbAccess;
    logic                    apbWrite;
    logic                    flagWrite;
    logic                    boundary;
    logic                    acceptTrap;
    logic                    acceptMask;
    logic                    acceptAny;
    logic [15:0]             ackClr;

    // Register decode, shared by write decode and error answer
    function automatic logic isMapped(input logic [7:0] a);
        return a == intack_pkg::ADDR_REQ || a == intack_pkg::ADDR_MASK ||
               a == intack_pkg::ADDR_LEVEL || a == intack_pkg::ADDR_STATUS ||
               a == intack_pkg::ADDR_ACKINFO;
    endfunction : isMapped

    assign pready         = pready_q;
    assign prdata         = prdata_q;
    assign pslverr        = pslverr_q;
    assign ackBusy        = state_q == intack_pkg::ACK_SAVE;
    assign stackPush      = stackPush_q;
    assign stackData      = stackData_q;
    assign vectorLoad     = vectorLoad_q;
    assign serviceStart   = serviceStart_q;
    assign statusWord     = statusQ;

    // Bus write lands on the edge where pready is seen high
    assign apbAccess = psel & penable;
    assign apbWrite  = apbAccess & pready_q & pwrite & isMapped(paddr);
    assign flagWrite = apbWrite & (paddr != intack_pkg::ADDR_ACKINFO);

    // Acceptance is judged only at an instruction boundary while idle
    assign eligible   = reqQ & ~maskQ;                                     // RULE_01
    assign boundary   = instrDone & (state_q == intack_pkg::ACK_IDLE);
    assign acceptTrap = boundary & instrTrap;                              // RULE_12
    // Trap wins the boundary since it clears the accept flag anyway
    assign acceptMask = boundary & ~instrTrap & anyValid                   // RULE_07
                        & statusQ[intack_pkg::ST_ACCEPT]                   // RULE_02
                        & (~winLevel | statusQ[intack_pkg::ST_INSERV])     // RULE_14
                        & ~instrHold & ~regTouch_q & ~flagWrite            // RULE_17
                        & ~instrRetMaskable & ~instrRetTrap                // RULE_16
                        & ~instrAcceptOn & ~instrAcceptOff;                // RULE_17
    assign acceptAny  = acceptTrap | acceptMask;
    assign ackClr     = acceptMask ? (16'h0001 << winIdx) : 16'h0000;

    source_arbiter u_arbiter
    (
        .eligible (eligible),
        .level    (levelQ),
        .anyValid (anyValid),
        .winIdx   (winIdx),
        .winLevel (winLevel)
    );

    vector_locator u_locator
    (
        .clock            (clock),
        .rst_b            (rst_b),
        .load             (acceptAny),
        .isTrap           (acceptTrap),
        .srcIdx           (winIdx),
        .vectorLocation_q (vectorLocation)
    );

    // APB answer with one wait state; read data prepared in that cycle
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q  <= apbAccess & ~pready_q;
            pslverr_q <= apbAccess & ~pready_q & ~isMapped(paddr);
            prdata_q  <= 32'h0000_0000;
            if (apbAccess & ~pready_q & ~pwrite)
            begin
                case (paddr)
                    intack_pkg::ADDR_REQ:     prdata_q <= {16'h0000, reqQ};
                    intack_pkg::ADDR_MASK:    prdata_q <= {16'h0000, maskQ};
                    intack_pkg::ADDR_LEVEL:   prdata_q <= {16'h0000, levelQ};
                    intack_pkg::ADDR_STATUS:  prdata_q <= {24'h000000, statusQ};
                    intack_pkg::ADDR_ACKINFO: prdata_q <= {26'h0000000, ackBusy,
                                                           lastTrap_q, lastSrc_q};
                    default:                  prdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Request flags: events win over software clears and acceptance
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            reqQ <= intack_pkg::REQ_RST;
        end
        else if (apbWrite && paddr == intack_pkg::ADDR_REQ)
        begin
            reqQ <= (pwdata[15:0] & ~ackClr) | sourceEvent;   // RULE_19
        end
        else
        begin
            reqQ <= (reqQ & ~ackClr) | sourceEvent;           // RULE_22
        end
    end

    // Mask and level registers
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            maskQ  <= intack_pkg::MASK_RST;
            levelQ <= intack_pkg::LEVEL_RST;                  // RULE_21
        end
        else
        begin
            if (apbWrite && paddr == intack_pkg::ADDR_MASK)
            begin
                maskQ <= pwdata[15:0];
            end
            if (apbWrite && paddr == intack_pkg::ADDR_LEVEL)
            begin
                levelQ <= pwdata[15:0];
            end
        end
    end

    // Status word; instruction effects take precedence over a bus write
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            statusQ <= intack_pkg::STATUS_RST;                // RULE_20
        end
        else if (acceptMask)
        begin
            statusQ[intack_pkg::ST_ACCEPT] <= 1'b0;           // RULE_08
            statusQ[intack_pkg::ST_INSERV] <= winLevel;       // RULE_15
        end
        else if (acceptTrap)
        begin
            statusQ[intack_pkg::ST_ACCEPT] <= 1'b0;           // RULE_18
        end
        else if (boundary && (instrRetMaskable || instrRetTrap))
        begin
            statusQ <= restoredStatus;                        // RULE_10
        end
        else if (boundary && instrAcceptOn)
        begin
            statusQ[intack_pkg::ST_ACCEPT] <= 1'b1;
        end
        else if (boundary && instrAcceptOff)
        begin
            statusQ[intack_pkg::ST_ACCEPT] <= 1'b0;
        end
        else if (apbWrite && paddr == intack_pkg::ADDR_STATUS)
        begin
            statusQ <= pwdata[7:0];
        end
    end

    // A flag register write holds acceptance past the next boundary
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            regTouch_q <= 1'b0;
        end
        else if (flagWrite)
        begin
            regTouch_q <= 1'b1;                               // RULE_17
        end
        else if (instrDone)
        begin
            regTouch_q <= 1'b0;
        end
    end

    // Save sequence; long instructions such as divide simply delay instrDone
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q       <= intack_pkg::ACK_IDLE;
            seqCnt_q      <= 3'h0;
            seqLast_q     <= intack_pkg::SEQ_LAST_HI;
            savedStatus_q <= intack_pkg::STATUS_RST;
            savedPc_q     <= 16'h0000;
            lastTrap_q    <= 1'b0;
            lastSrc_q     <= 4'h0;
        end
        else
        begin
            case (state_q)
                intack_pkg::ACK_IDLE:
                begin
                    seqCnt_q <= 3'h0;
                    if (acceptAny)                            // RULE_04
                    begin
                        state_q       <= intack_pkg::ACK_SAVE;
                        savedStatus_q <= statusQ;
                        savedPc_q     <= currentPc;
                        lastTrap_q    <= acceptTrap;
                        lastSrc_q     <= acceptTrap ? 4'h0 : winIdx;
                        // Low level costs one extra clock
                        seqLast_q     <= (acceptMask && winLevel) ?
                                         intack_pkg::SEQ_LAST_LO :
                                         intack_pkg::SEQ_LAST_HI;  // RULE_03
                    end
                end
                intack_pkg::ACK_SAVE:
                begin
                    seqCnt_q <= seqCnt_q + 3'h1;
                    if (seqCnt_q == seqLast_q)
                    begin
                        state_q <= intack_pkg::ACK_IDLE;
                    end
                end
                default:
                begin
                    state_q <= intack_pkg::ACK_IDLE;
                end
            endcase
        end
    end

    // Stack pushes, vector fetch and service start strobes
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stackPush_q    <= 1'b0;
            stackData_q    <= 16'h0000;
            vectorLoad_q   <= 1'b0;
            serviceStart_q <= 1'b0;
        end
        else
        begin
            stackPush_q    <= 1'b0;
            vectorLoad_q   <= 1'b0;
            serviceStart_q <= 1'b0;
            if (ackBusy)
            begin
                if (seqCnt_q == intack_pkg::SEQ_PUSH_ST)
                begin
                    stackPush_q <= 1'b1;                      // RULE_08
                    stackData_q <= {8'h00, savedStatus_q};
                end
                if (seqCnt_q == intack_pkg::SEQ_PUSH_PC)
                begin
                    stackPush_q <= 1'b1;                      // RULE_11
                    stackData_q <= savedPc_q;
                end
                if (seqCnt_q == intack_pkg::SEQ_VECTOR)
                begin
                    vectorLoad_q <= 1'b1;                     // RULE_09
                end
                if (seqCnt_q == seqLast_q)
                begin
                    serviceStart_q <= 1'b1;                   // RULE_03
                end
            end
        end
    end

    a_eligible_only: assert property (@(posedge clock) disable iff (!rst_b)
        acceptMask |-> reqQ[winIdx] && !maskQ[winIdx])                    // RULE_01
        else $error("accepted source not eligible");

    a_accept_gate: assert property (@(posedge clock) disable iff (!rst_b)
        acceptMask |-> statusQ[intack_pkg::ST_ACCEPT])                     // RULE_02
        else $error("maskable accepted with accept flag clear");

    a_high_latency: assert property (@(posedge clock) disable iff (!rst_b)
        acceptMask && !winLevel |-> !serviceStart_q [*6] ##1 serviceStart_q) // RULE_03
        else $error("high level service start not six clocks after accept");

    a_low_latency: assert property (@(posedge clock) disable iff (!rst_b)
        acceptMask && winLevel |-> ##7 serviceStart_q)                     // RULE_03
        else $error("low level service start not seven clocks after accept");

    a_level_first: assert property (@(posedge clock) disable iff (!rst_b)
        acceptMask && winLevel |-> (eligible & ~levelQ) == 16'h0000)       // RULE_05
        else $error("low level taken over a high level request");

    a_default_order: assert property (@(posedge clock) disable iff (!rst_b)
        acceptMask |-> ((eligible & (winLevel ? levelQ : ~levelQ))
                        & ((16'h0001 << winIdx) - 16'h0001)) == 16'h0000)  // RULE_06
        else $error("default priority order violated");

    a_save_order: assert property (@(posedge clock) disable iff (!rst_b)
        acceptAny |=> ##1 stackPush_q && stackData_q == {8'h00, savedStatus_q}
                      ##1 stackPush_q && stackData_q == savedPc_q)         // RULE_08
        else $error("status and counter not pushed in order");

    a_accept_flags: assert property (@(posedge clock) disable iff (!rst_b)
        acceptMask |=> !statusQ[intack_pkg::ST_ACCEPT]
                       && statusQ[intack_pkg::ST_INSERV] == $past(winLevel)) // RULE_08
        else $error("status flags not updated on accept");

    a_trap_vector: assert property (@(posedge clock) disable iff (!rst_b)
        acceptTrap |=> vectorLocation == intack_pkg::TRAP_VECTOR ##3 vectorLoad_q) // RULE_11
        else $error("trap vector location wrong");

    a_trap_uncond: assert property (@(posedge clock) disable iff (!rst_b)
        boundary && instrTrap |=> ackBusy && !statusQ[intack_pkg::ST_ACCEPT]) // RULE_12
        else $error("trap not taken unconditionally");

    a_nest_block: assert property (@(posedge clock) disable iff (!rst_b)
        acceptMask |-> !winLevel || statusQ[intack_pkg::ST_INSERV])         // RULE_14
        else $error("lower priority nested over high service");

    a_hold_defers: assert property (@(posedge clock) disable iff (!rst_b)
        instrDone && (instrHold || regTouch_q || instrRetMaskable) |-> !acceptMask) // RULE_17
        else $error("accept not deferred after hold instruction");

endmodule : cpu_interrupt_acknowledge_logic

/* File: rtl/source_arbiter.sv */
`timescale 1ns/10ps
module source_arbiter
(
    // Candidates
    input  wire logic [15:0] eligible,
    input  wire logic [15:0] level,
    // Winner
    output logic             anyValid,
    output logic [3:0]       winIdx,
    output logic             winLevel
);

    // Lowest index set bit is the highest default priority
    function automatic logic [3:0] lowestSet(input logic [15:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = intack_pkg::NSRC - 1; i >= 0; i--)
        begin
            if (v[i])
            begin
                r = 4'(i);
            end
        end
        return r;
    endfunction : lowestSet

    logic [15:0] highSet;

    // High group first, then default order inside the group
    always_comb
    begin
        highSet  = eligible & ~level;                  // RULE_05
        anyValid = |eligible;
        if (|highSet)
        begin
            winIdx = lowestSet(highSet);               // RULE_06
        end
        else
        begin
            winIdx = lowestSet(eligible);              // RULE_06
        end
        winLevel = ~(|highSet);
    end

endmodule : source_arbiter

/* File: rtl/vector_locator.sv */
`timescale 1ns/10ps
module vector_locator
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_b,
    // Request
    input  wire logic        load,
    input  wire logic        isTrap,
    input  wire logic [3:0]  srcIdx,
    // Table location
    output logic [15:0]      vectorLocation_q
);

    // Each source owns a two-byte entry above the base
    function automatic logic [15:0] entryFor(input logic [3:0] idx);
        return intack_pkg::VEC_BASE + {11'h000, idx, 1'b0};
    endfunction : entryFor

    // Captured on acceptance so it stays stable through the save
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            vectorLocation_q <= 16'h0000;
        end
        else if (load)
        begin
            if (isTrap)
            begin
                vectorLocation_q <= intack_pkg::TRAP_VECTOR;  // RULE_11
            end
            else
            begin
                vectorLocation_q <= entryFor(srcIdx);         // RULE_09
            end
        end
    end

endmodule : vector_locator

/* File: test/cpu_sequencer_model.sv */
`timescale 1ns/10ps
module cpu_sequencer_model
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_b,
    // Bench control
    input  wire logic        go,
    // Save sequence
    input  wire logic        ackBusy,
    input  wire logic        stackPush,
    input  wire logic [15:0] stackData,
    // Sequencer outputs
    output logic             instrDone,
    output logic [15:0]      savedSt,
    output logic [15:0]      savedPc
);
    logic pushNum_q;

    // Every other cycle, so no boundary lands while the save runs
    always_ff @(posedge clock or negedge rst_b)
        if (!rst_b)
            instrDone <= 1'b0;
        else
            instrDone <= go && !ackBusy && !instrDone;

    // Stack: first word is status, second the counter
    always_ff @(posedge clock or negedge rst_b)
        if (!rst_b)
            pushNum_q <= 1'b0;
        else if (stackPush)
        begin
            pushNum_q <= !pushNum_q;
            if (!pushNum_q)
                savedSt <= stackData;
            else
                savedPc <= stackData;
        end
endmodule : cpu_sequencer_model

/* File: test/testbench.sv */
`timescale 1ns/10ps
module testbench;
    logic        clock, rst_b, psel, penable, pwrite, pready, pslverr, go, err;
    logic        instrDone, instrHold, instrTrap, instrRetMaskable, instrRetTrap;
    logic        instrAcceptOn, instrAcceptOff, ackBusy, stackPush, vectorLoad, serviceStart;
    logic [7:0]  paddr, restoredStatus, statusWord;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] sourceEvent, stackData, vectorLocation, savedSt, savedPc;
    int          miscompares, samplesChecked, lat;

    cpu_interrupt_acknowledge_logic cpu_interrupt_acknowledge_logic_i (.clock(clock),
        .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .sourceEvent(sourceEvent), .instrDone(instrDone), .instrHold(instrHold),
        .instrTrap(instrTrap), .instrRetMaskable(instrRetMaskable),
        .instrRetTrap(instrRetTrap), .instrAcceptOn(instrAcceptOn),
        .instrAcceptOff(instrAcceptOff), .restoredStatus(restoredStatus),
        .currentPc(16'h1234), .ackBusy(ackBusy), .stackPush(stackPush),
        .stackData(stackData), .vectorLoad(vectorLoad), .vectorLocation(vectorLocation),
        .serviceStart(serviceStart), .statusWord(statusWord));
    cpu_sequencer_model cpu_sequencer_model_i (.clock(clock), .rst_b(rst_b), .go(go),
        .ackBusy(ackBusy), .stackPush(stackPush), .stackData(stackData),
        .instrDone(instrDone), .savedSt(savedSt), .savedPc(savedPc));

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // Setup, access, then wait for the answer; data taken at the ready edge
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask : apb

    // One instruction boundary, qualifiers dropped after it
    task step();
        go <= 1'b1;
        do @(posedge clock); while (instrDone !== 1'b1);
        go <= 1'b0;
        {instrHold, instrTrap, instrRetMaskable, instrRetTrap} <= '0;
        {instrAcceptOn, instrAcceptOff} <= '0;
        @(posedge clock);
    endtask : step

    task ev(input logic [15:0] m);
        sourceEvent <= m;
        @(posedge clock);
        sourceEvent <= '0;
    endtask : ev

    // Run the program until a service routine starts
    task svc(input logic [15:0] v, input logic [7:0] s);
        go <= 1'b1;
        lat = 0;
        do begin @(posedge clock); lat++; end while (serviceStart !== 1'b1 && lat < 60);
        chk("service start", serviceStart, 1'b1);
        chk("vector", vectorLocation, v);
        chk("status", statusWord, s);
        go <= 1'b0;
        @(posedge clock);
    endtask : svc

    task quiet();
        logic hit;
        hit = 1'b0;
        go <= 1'b1;
        repeat (24) begin @(posedge clock); hit = hit | serviceStart; end
        chk("no service", hit, 0);
        go <= 1'b0;
        @(posedge clock);
    endtask : quiet

    task t_reset();
        chk("reset status", statusWord, 8'h02);
        apb(1'b0, 8'h08, '0);
        chk("reset level", rd, 32'h0000ffff);
        apb(1'b0, 8'h14, '0);
        chk("unmapped err", err, 1'b1);
    endtask : t_reset

    task t_accept();
        apb(1'b1, 8'h04, 32'h0);
        apb(1'b1, 8'h08, 32'hfff7);
        instrAcceptOn <= 1'b1;
        step();
        step();
        ev(16'h0008);
        svc(16'h000a, 8'h00);
        chk("latency", lat >= 7 && lat <= 32, 1);
        chk("pushed status", savedSt, 16'h0082);
        chk("pushed pc", savedPc, 16'h1234);
        apb(1'b0, 8'h00, '0);
        chk("flag cleared", rd, 32'h0);
    endtask : t_accept

    // Low level waits behind a high-level service, then runs after return
    task t_nest();
        instrAcceptOn <= 1'b1;
        step();
        ev(16'h0004);
        quiet();
        instrRetMaskable <= 1'b1;
        restoredStatus <= 8'h82;
        step();
        svc(16'h0008, 8'h02);
    endtask : t_nest

    task t_prio();
        instrRetMaskable <= 1'b1;
        restoredStatus <= 8'h82;
        step();
        ev(16'h000a);
        svc(16'h000a, 8'h00);
        instrRetMaskable <= 1'b1;
        restoredStatus <= 8'h02;
        step();
        ev(16'h0040);
        instrAcceptOn <= 1'b1;
        step();
        svc(16'h0006, 8'h02);
    endtask : t_prio

    // Trap with accepting off; the pending source stays blocked
    task t_trap();
        instrTrap <= 1'b1;
        step();
        svc(16'h003e, 8'h02);
        chk("trap status push", savedSt, 16'h0002);
        apb(1'b0, 8'h10, '0);
        chk("trap info", rd, 32'h00000010);
        instrRetTrap <= 1'b1;
        restoredStatus <= 8'h82;
        step();
        instrAcceptOff <= 1'b1;
        step();
        quiet();
    endtask : t_trap

    task end_of_test();
        $display("checked %0d mismatches %0d", samplesChecked, miscompares);
        if (miscompares == 0 && samplesChecked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test

    initial
    begin
        clock = 1'b0;
        forever #10 clock = !clock;
    end

    // Whole run needs well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge clock);
        miscompares++;
        end_of_test();
    end

    initial
    begin
        {rst_b, psel, penable, pwrite, go, instrHold, instrTrap} = '0;
        {instrRetMaskable, instrRetTrap, instrAcceptOn, instrAcceptOff} = '0;
        {paddr, restoredStatus, pwdata, sourceEvent} = '0;
        repeat (5) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        t_reset();
        t_accept();
        t_nest();
        t_prio();
        t_trap();
        end_of_test();
    end
endmodule : testbench
